// File: cel_chk.sv
// port checker for the comparator event logic
`timescale 1ns/1ps
`default_nettype none
module cel_chk (
    input wire logic       i_clk_sys,
    input wire logic       i_rst,
    input wire logic [8:0] i_trig_cfg,
    input wire logic [8:0] i_int_cfg,
    input wire logic [2:0] i_out_invert,
    input wire logic [2:0] i_int_en,
    input wire logic [2:0] i_int_clear,
    input wire logic [2:0] o_pin_out,
    input wire logic [2:0] o_pin_oe,
    input wire logic [2:0] o_value,
    input wire logic [2:0] o_int_raw,
    input wire logic [2:0] o_int_masked,
    input wire logic       o_irq,
    input wire logic [2:0] o_adc_trigger
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    // edge relations are watched on comparator 0 only; the bench covers the other indices
    pin_copy_a: assert property (o_pin_out == (o_pin_oe & (o_value ^ $past(i_out_invert))))
        else $error("pin copy wrong");
    status_mask_a: assert property (o_int_masked == (o_int_raw & $past(i_int_en)))
        else $error("masked status wrong");
    irq_or_a: assert property (o_irq == |o_int_masked)
        else $error("irq wrong");
    trig_rise_a: assert property ($rose(o_value[0]) && $past(i_trig_cfg[2:0]) == 3'h4 |-> o_adc_trigger[0])
        else $error("missing trigger");
    trig_off_a: assert property ($past(i_trig_cfg[2:0]) == 3'h0 |-> !o_adc_trigger[0])
        else $error("trigger while off");
    level_status_a: assert property ($past(i_int_cfg[2:0]) == 3'h1 |-> o_int_raw[0] == o_value[0])
        else $error("level status wrong");
    edge_sticky_a: assert property (o_int_raw[0] && !i_int_clear[0] && i_int_cfg[2:0] == 3'h4
        |=> o_int_raw[0])
        else $error("edge status lost");
    edge_clear_a: assert property (i_int_clear[0] && i_int_cfg[2:0] == 3'h4
        |=> o_int_raw[0] == $rose(o_value[0]))
        else $error("clear failed");
    irq_seen_c: cover property ($rose(o_irq));
    clear_seen_c: cover property ($fell(o_int_raw[0]));
    pulse_seen_c: cover property (o_adc_trigger[0] ##1 !o_adc_trigger[0]);
endmodule
`default_nettype wire

// File: cel_far_model.sv
// far side: adc sequence starts and a service routine that clears early
`timescale 1ns/1ps
`default_nettype none
module cel_far_model (
    input wire logic       i_clk_sys,
    input wire logic       i_rst,
    input wire logic [2:0] i_adc_trigger,
    input wire logic       i_irq,
    input wire logic       i_service,
    output logic     [2:0] o_int_clear,
    output int             o_starts
);
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_starts <= 0;
            o_int_clear <= 3'h0;
        end else begin
            o_starts <= o_starts + $countones(i_adc_trigger);
            // clear at once on entry; a late clear would re-enter the handler
            o_int_clear <= {3{i_irq & i_service & ~|o_int_clear}};
        end
    end
endmodule
`default_nettype wire

// File: cel_pkg.sv
// package with constants and types for the comparator event logic
//
// Operation
// - interrupt and adc trigger conditions use separate logic and separate settings
// - trigger setting: off, level high, level low, falling, rising, any edge
// - interrupt setting: level high, level low, falling, rising, any edge
// - reference select: own pin, shared comparator 0 pin, or internal reference
// - result drives a pin when enabled, normal or inverted
// - software clear drops interrupt, but not while selected level persists
// - interrupt reaches processor only while its enable is set
// - raw and masked interrupt status readable per comparator
// - qualifying trigger edge pulses the adc sequence start; a trigger level holds it high while it lasts
// - software reads present comparator result, one high, zero low
package cel_pkg;
    localparam int unsigned NUM_COMP   = 3;
    localparam int unsigned CEL_TRIG_W = 3;
    localparam int unsigned CEL_INT_W  = 3;
    localparam int unsigned CEL_REF_W  = 2;

    typedef enum logic [2:0] {
        adc_trigger_off          = 3'h0,
        adc_trigger_level_high   = 3'h1,
        adc_trigger_level_low    = 3'h2,
        adc_trigger_falling_edge = 3'h3,
        adc_trigger_rising_edge  = 3'h4,
        adc_trigger_any_edge     = 3'h5
    } cel_trig_t;

    typedef enum logic [2:0] {
        int_level_high   = 3'h1,
        int_level_low    = 3'h2,
        int_falling_edge = 3'h3,
        int_rising_edge  = 3'h4,
        int_any_edge     = 3'h5
    } cel_int_t;

    typedef enum logic [1:0] {
        ref_from_own_pin    = 2'h0,
        ref_from_shared_pin = 2'h1,
        ref_from_internal   = 2'h2
    } cel_ref_t;

    localparam logic [2:0] CEL_INT_RESET = 3'h1;
endpackage

// File: cel_sync.sv
// two flop synchroniser for the comparator results
`timescale 1ns/1ps
`default_nettype none
module cel_sync
    import cel_pkg::*;
(
    input  wire logic  i_clk_sys,
    input  wire logic  i_rst,
    cel_sync_if.syn    s
);
    logic [NUM_COMP-1:0] meta_ff;
    logic [NUM_COMP-1:0] sync_ff;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= s.raw;
            sync_ff <= meta_ff;
        end
    end

    assign s.sync = sync_ff;
endmodule
`default_nettype wire

// File: cel_sync_if.sv
// interface carrying the raw and synchronised comparator results
`timescale 1ns/1ps
`default_nettype none
interface cel_sync_if;
    logic [cel_pkg::NUM_COMP-1:0] raw;
    logic [cel_pkg::NUM_COMP-1:0] sync;
    modport src (output raw, input sync);
    modport syn (input raw, output sync);
endinterface
`default_nettype wire

// File: cel_top.sv
// comparator event logic: interrupt, adc trigger, pin output, reference select
`timescale 1ns/1ps
`default_nettype none
module cel_top
    import cel_pkg::*;
(
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rst,
    input  wire logic [NUM_COMP-1:0]   i_cmp_result,
    input  wire logic [NUM_COMP*3-1:0] i_trig_cfg,
    input  wire logic [NUM_COMP*3-1:0] i_int_cfg,
    input  wire logic [NUM_COMP*2-1:0] i_ref_cfg,
    input  wire logic [NUM_COMP-1:0]   i_out_en,
    input  wire logic [NUM_COMP-1:0]   i_out_invert,
    input  wire logic [NUM_COMP-1:0]   i_int_en,
    input  wire logic [NUM_COMP-1:0]   i_int_clear,
    output logic      [NUM_COMP-1:0]   o_pin_out,
    output logic      [NUM_COMP-1:0]   o_pin_oe,
    output logic      [NUM_COMP*2-1:0] o_ref_sel,
    output logic      [NUM_COMP-1:0]   o_value,
    output logic      [NUM_COMP-1:0]   o_int_raw,
    output logic      [NUM_COMP-1:0]   o_int_masked,
    output logic                       o_irq,
    output logic      [NUM_COMP-1:0]   o_adc_trigger
);
    // ------------------------------------------------------------
    // synchronise and detect edges
    // ------------------------------------------------------------
    cel_sync_if sif ();
    assign sif.raw = i_cmp_result;

    cel_sync u_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .s         (sif)
    );

    logic [NUM_COMP-1:0] prev_ff;
    wire  [NUM_COMP-1:0] cur  = sif.sync;
    wire  [NUM_COMP-1:0] rise = cur & ~prev_ff;
    wire  [NUM_COMP-1:0] fall = ~cur & prev_ff;

    // ------------------------------------------------------------
    // edge history
    // ------------------------------------------------------------
    // history starts low with the synchroniser: a result already high at release
    // shows one rising edge a few cycles later, which software must expect
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            prev_ff <= '0;
        end else begin
            prev_ff <= cur;
        end
    end

    // ------------------------------------------------------------
    // condition decoders
    // ------------------------------------------------------------
    // trigger and interrupt each get a decoder of their own, fed by their own setting
    function automatic logic trig_hit_of(input logic [CEL_TRIG_W-1:0] sel, input logic lvl,
                                         input logic r, input logic f);
        case (sel)
            adc_trigger_level_high:   trig_hit_of = lvl;
            adc_trigger_level_low:    trig_hit_of = ~lvl;
            adc_trigger_falling_edge: trig_hit_of = f;
            adc_trigger_rising_edge:  trig_hit_of = r;
            adc_trigger_any_edge:     trig_hit_of = r | f;
            default:                  trig_hit_of = 1'b0;
        endcase
    endfunction

    // undefined codes, zero included, raise no interrupt at all
    function automatic logic int_hit_of(input logic [CEL_INT_W-1:0] sel, input logic lvl,
                                        input logic r, input logic f);
        case (sel)
            int_level_high:   int_hit_of = lvl;
            int_level_low:    int_hit_of = ~lvl;
            int_falling_edge: int_hit_of = f;
            int_rising_edge:  int_hit_of = r;
            int_any_edge:     int_hit_of = r | f;
            default:          int_hit_of = 1'b0;
        endcase
    endfunction

    function automatic logic is_level(input logic [CEL_INT_W-1:0] sel);
        is_level = (sel == int_level_high) || (sel == int_level_low);
    endfunction

    // the unused code falls back to the own pin so the reference mux never sees it;
    // for comparator 0 the shared pin and the own pin are the same input
    function automatic logic [CEL_REF_W-1:0] ref_code(input logic [CEL_REF_W-1:0] sel);
        case (sel)
            ref_from_shared_pin: ref_code = ref_from_shared_pin;
            ref_from_internal:   ref_code = ref_from_internal;
            default:             ref_code = ref_from_own_pin;
        endcase
    endfunction

    // ------------------------------------------------------------
    // adc trigger decode
    // ------------------------------------------------------------
    logic [NUM_COMP-1:0] trig_hit;

    for (genvar g = 0; g < NUM_COMP; g++) begin : g_trig
        wire [CEL_TRIG_W-1:0] tsel = i_trig_cfg[g*CEL_TRIG_W +: CEL_TRIG_W];
        assign trig_hit[g] = trig_hit_of(tsel, cur[g], rise[g], fall[g]);
    end

    // ------------------------------------------------------------
    // interrupt decode
    // ------------------------------------------------------------
    logic [NUM_COMP-1:0] int_hit;
    logic [NUM_COMP-1:0] lvl_int;
    logic [NUM_COMP-1:0] int_ff;
    logic [NUM_COMP-1:0] nxt_int;

    for (genvar g = 0; g < NUM_COMP; g++) begin : g_int
        wire [CEL_INT_W-1:0] isel = i_int_cfg[g*CEL_INT_W +: CEL_INT_W];
        assign int_hit[g] = int_hit_of(isel, cur[g], rise[g], fall[g]);
        assign lvl_int[g] = is_level(isel);
    end

    // level: status tracks the condition, so a clear cannot drop it while the level lasts
    // edge: sticky; an edge in the clearing cycle wins, so no event is lost
    assign nxt_int = (lvl_int & int_hit)
                   | (~lvl_int & (int_hit | (int_ff & ~i_int_clear)));

    // ------------------------------------------------------------
    // interrupt status
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            int_ff <= '0;
        end else begin
            int_ff <= nxt_int;
        end
    end

    // ------------------------------------------------------------
    // status outputs
    // ------------------------------------------------------------
    // the mask hides the interrupt but keeps the raw status readable for polling
    wire [NUM_COMP-1:0] nxt_int_masked = nxt_int & i_int_en;
    wire                nxt_irq        = |nxt_int_masked;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_int_raw    <= '0;
            o_int_masked <= '0;
        end else begin
            o_int_raw    <= nxt_int;
            o_int_masked <= nxt_int_masked;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= nxt_irq;
        end
    end

    // ------------------------------------------------------------
    // adc trigger output
    // ------------------------------------------------------------
    // level settings hold the start line high for as long as the level lasts
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_adc_trigger <= '0;
        end else begin
            o_adc_trigger <= trig_hit;
        end
    end

    // ------------------------------------------------------------
    // pin output
    // ------------------------------------------------------------
    // a disabled pin is held low so the pad never shows a stale result
    wire [NUM_COMP-1:0] nxt_pin_out = (cur ^ i_out_invert) & i_out_en;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_pin_out <= '0;
            o_pin_oe  <= '0;
        end else begin
            o_pin_out <= nxt_pin_out;
            o_pin_oe  <= i_out_en;
        end
    end

    // ------------------------------------------------------------
    // reference select
    // ------------------------------------------------------------
    logic [NUM_COMP*CEL_REF_W-1:0] nxt_ref_sel;

    for (genvar g = 0; g < NUM_COMP; g++) begin : g_ref
        assign nxt_ref_sel[g*CEL_REF_W +: CEL_REF_W] = ref_code(i_ref_cfg[g*CEL_REF_W +: CEL_REF_W]);
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_ref_sel <= '0;
        end else begin
            o_ref_sel <= nxt_ref_sel;
        end
    end

    // ------------------------------------------------------------
    // result readback
    // ------------------------------------------------------------
    // readback trails the comparator by the two synchroniser stages and this flop
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_value <= '0;
        end else begin
            o_value <= cur;
        end
    end
endmodule
`default_nettype wire

// File: cel_top_bench.sv
// self-checking bench for the comparator event logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; \
    $display("wrong value %0t %h %h", $time, a, b); end end
module cel_top_bench
    import cel_pkg::*;
;
    typedef struct {logic [2:0] tc, ic; logic v0, v1; int nt; logic raw; logic [1:0] rf; logic inv, en;} cel_row_t;
    logic i_clk_sys, i_rst, svc, o_irq;
    logic [2:0] i_cmp_result, i_out_en, i_out_invert, i_int_en, clr, far_clr, i_int_clear;
    logic [2:0] o_pin_out, o_pin_oe, o_value, o_int_raw, o_int_masked, o_adc_trigger;
    logic [8:0] i_trig_cfg, i_int_cfg;
    logic [5:0] i_ref_cfg, o_ref_sel;
    int fail_count, n_compared, starts, g;
    logic [3:0] ntrig;
    // trig, int, start, end, trigger cycles, status, ref, invert, enable
    cel_row_t rows[7] = '{'{3'h0, 3'h4, 0, 1, 0, 1, 2'h0, 0, 1}, '{3'h1, 3'h3, 0, 1, 6, 0, 2'h1, 1, 1},
        '{3'h2, 3'h3, 1, 0, 6, 1, 2'h2, 0, 0}, '{3'h3, 3'h1, 1, 0, 1, 0, 2'h3, 1, 1},
        '{3'h4, 3'h2, 0, 1, 1, 0, 2'h0, 0, 1}, '{3'h5, 3'h5, 1, 0, 1, 1, 2'h1, 1, 0},
        '{3'h5, 3'h1, 0, 1, 1, 1, 2'h2, 0, 1}};
    assign i_int_clear = clr | far_clr;
    cel_top u_cel_top (
        .i_clk_sys     (i_clk_sys),
        .i_rst         (i_rst),
        .i_cmp_result  (i_cmp_result),
        .i_trig_cfg    (i_trig_cfg),
        .i_int_cfg     (i_int_cfg),
        .i_ref_cfg     (i_ref_cfg),
        .i_out_en      (i_out_en),
        .i_out_invert  (i_out_invert),
        .i_int_en      (i_int_en),
        .i_int_clear   (i_int_clear),
        .o_pin_out     (o_pin_out),
        .o_pin_oe      (o_pin_oe),
        .o_ref_sel     (o_ref_sel),
        .o_value       (o_value),
        .o_int_raw     (o_int_raw),
        .o_int_masked  (o_int_masked),
        .o_irq         (o_irq),
        .o_adc_trigger (o_adc_trigger)
    );
    cel_far_model u_cel_far_model (.i_clk_sys, .i_rst, .i_adc_trigger(o_adc_trigger), .i_irq(o_irq),
        .i_service(svc), .o_int_clear(far_clr), .o_starts(starts));
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end
    initial begin
        #20000;
        fail_count++;
        final_report();
    end
    initial begin
        {svc, i_cmp_result, i_out_en, i_out_invert, i_int_en, clr, i_trig_cfg, i_int_cfg, i_ref_cfg} = '0;
        i_rst = 1'b1;
        repeat (16) @(negedge i_clk_sys);
        i_rst = 1'b0;
        for (int i = 0; i < 7; i++) begin
            g = i % 3;
            i_cmp_result[g] = rows[i].v0;
            i_trig_cfg[g*3+:3] = rows[i].tc;
            i_int_cfg[g*3+:3] = rows[i].ic;
            i_ref_cfg[g*2+:2] = rows[i].rf;
            i_out_invert[g] = rows[i].inv;
            i_out_en[g] = rows[i].en;
            i_int_en = 3'h0;
            i_int_en[g] = rows[i].en;
            clr[g] = 1'b1;
            repeat (6) @(negedge i_clk_sys);
            clr[g] = 1'b0;
            i_cmp_result[g] = rows[i].v1;
            ntrig = 0;
            repeat (8) begin
                @(negedge i_clk_sys);
                ntrig += o_adc_trigger[g];
            end
            `CHK(ntrig, rows[i].nt)
            `CHK(o_value[g], rows[i].v1)
            `CHK(o_int_raw[g], rows[i].raw)
            `CHK({o_irq, o_int_masked[g]}, {2{rows[i].raw & rows[i].en}})
            `CHK({o_pin_oe[g], o_pin_out[g]}, {rows[i].en, rows[i].en & (rows[i].v1 ^ rows[i].inv)})
            `CHK(o_ref_sel[g*2+:2], rows[i].rf == 2'h3 ? 2'h0 : rows[i].rf)
        end
        // level status on comparator 0 ignores a clear while the level lasts
        clr[0] = 1'b1;
        @(negedge i_clk_sys);
        clr[0] = 1'b0;
        @(negedge i_clk_sys);
        `CHK(o_int_raw[0], 1'b1)
        i_cmp_result[0] = 1'b0;
        repeat (5) @(negedge i_clk_sys);
        `CHK(o_int_raw[0], 1'b0)
        {i_int_cfg[2:0], i_trig_cfg[2:0], i_int_en, i_cmp_result[0]} = {3'h4, 3'h4, 3'h0, 1'b1};
        repeat (5) @(negedge i_clk_sys);
        `CHK({o_int_raw[0], o_irq}, 2'h2)
        i_int_en[0] = 1'b1;
        svc = 1'b1;
        @(negedge i_clk_sys);
        `CHK(o_int_masked[0], 1'b1)
        repeat (3) @(negedge i_clk_sys);
        `CHK(o_int_raw[0], 1'b0)
        {svc, i_rst, i_cmp_result, i_trig_cfg} = {1'b0, 1'b1, 3'h0, 9'h124};
        repeat (5) @(negedge i_clk_sys);
        `CHK({o_value, o_int_raw, o_adc_trigger, o_irq}, 10'h0)
        i_rst = 1'b0;
        repeat (4) @(negedge i_clk_sys);
        i_cmp_result = 3'h7;
        repeat (8) @(negedge i_clk_sys);
        `CHK(starts, 3)
        final_report();
    end
endmodule
bind cel_top cel_chk u_cel_chk (.*);
`default_nettype wire
